// file: dv/pmcm_manager_props.sv
// Concurrent checks on the power-mode manager's ports.
// Assumes a single 40 MHz domain with async high power-on reset.
`timescale 1ns/1ps
`include "pmcm_map.vh"
module pmcm_props #(
	parameter NPIN = 8
) (
	input wire logic            i_ref_clk,      // Reference clock
	input wire logic            i_rst,          // Power-on reset
	input wire logic            i_reset_pin,    // Reset pin
	input wire logic [1:0]      i_mode_req,     // Request code
	input wire logic            i_mode_req_vld, // Request strobe
	input wire logic            i_irq,          // Interrupt
	input wire logic            i_ext_wake,     // External wake
	input wire logic            i_rtc_event,    // Timer wake
	input wire logic [5:0]      o_mode,         // Mode state
	input wire logic            o_cpu_clk_en,   // Core clock
	input wire logic            o_aon_pwr_en,   // Always-on power
	input wire logic            o_sys_reset,    // Main reset
	input wire logic            o_fast_run,     // Fast clock run
	input wire logic            o_fast_src,     // Fast clock source
	input wire logic            o_radio_en,     // Radio on
	input wire logic            o_cpu_resume,   // Resume pulse
	input wire logic [NPIN-1:0] o_pad_out,      // Pad values
	input wire logic [NPIN-1:0] o_pad_oe_n      // Pad enables
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	// Wake settle steps
	sequence wake_entry;
		o_mode != `PMCM_ST_WAKE ##1 o_mode == `PMCM_ST_WAKE;
	endsequence
	sequence wake_settle;
		(o_mode == `PMCM_ST_WAKE)[*4] ##1 o_mode == `PMCM_ST_ACTIVE;
	endsequence
	property wake_seq_p;
		@(posedge i_ref_clk) disable iff (i_rst || i_reset_pin) wake_entry |-> wake_settle;
	endproperty
	req_taken_a: assert property (o_mode == `PMCM_ST_ACTIVE && i_mode_req_vld && i_mode_req != 2'h0 && !i_reset_pin
		|=> o_mode == (6'h01 << $past(i_mode_req))) else $error("mode request not taken");
	idle_gate_a: assert property (o_mode == `PMCM_ST_IDLE |-> !o_cpu_clk_en) else $error("core clocked in idle");
	irq_return_a: assert property (o_mode == `PMCM_ST_IDLE && i_irq && !i_reset_pin
		|=> o_mode == `PMCM_ST_ACTIVE) else $error("interrupt left idle held");
	idle_stay_a: assert property (o_mode == `PMCM_ST_IDLE && !i_irq && !i_reset_pin
		|=> o_mode == `PMCM_ST_IDLE) else $error("idle left without cause");
	stby_wake_a: assert property (o_mode == `PMCM_ST_STANDBY && (i_ext_wake || i_rtc_event) && !i_reset_pin
		|=> o_mode == `PMCM_ST_WAKE) else $error("standby wake missed");
	wake_settle_a: assert property (wake_seq_p) else $error("wake settle length wrong");
	resume_pulse_a: assert property (o_cpu_resume |-> $past(o_mode) == `PMCM_ST_WAKE
		&& o_mode == `PMCM_ST_ACTIVE) else $error("resume pulse misplaced");
	pad_hold_a: assert property ((o_mode == `PMCM_ST_STANDBY)[*3] |-> $stable(o_pad_out)
		&& $stable(o_pad_oe_n)) else $error("pads moved in standby");
	sd_power_a: assert property (o_mode == `PMCM_ST_SHUTDOWN |-> !o_aon_pwr_en && o_sys_reset)
		else $error("shutdown left power on");
	fast_clk_a: assert property (o_fast_run == (o_mode == `PMCM_ST_ACTIVE || o_mode == `PMCM_ST_IDLE))
		else $error("fast clock run wrong");
	radio_xtal_a: assert property (o_radio_en |-> o_fast_run && o_fast_src == `PMCM_HF_XTAL)
		else $error("radio without crystal");
	reset_held_a: assert property (i_reset_pin |=> o_mode == `PMCM_ST_HELD) else $error("reset pin ignored");
endmodule
bind pmcm_manager pmcm_props #(.NPIN(NPIN)) i_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
	.i_reset_pin(i_reset_pin), .i_mode_req(i_mode_req), .i_mode_req_vld(i_mode_req_vld), .i_irq(i_irq),
	.i_ext_wake(i_ext_wake), .i_rtc_event(i_rtc_event), .o_mode(o_mode), .o_cpu_clk_en(o_cpu_clk_en),
	.o_aon_pwr_en(o_aon_pwr_en), .o_sys_reset(o_sys_reset), .o_fast_run(o_fast_run), .o_fast_src(o_fast_src),
	.o_radio_en(o_radio_en), .o_cpu_resume(o_cpu_resume), .o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n));

// file: dv/pmcm_manager_tb.sv
// Self-checking bench for the power-mode manager.
// Assumes inputs driven on the falling edge and registered outputs.
`timescale 1ns/1ps
`include "pmcm_map.vh"
module power_mode_clock_manager_tb;
	reg        i_ref_clk = 0, i_rst = 1, i_reset_pin = 0, i_mode_req_vld = 0, i_irq = 0, i_ext_wake = 0;
	reg        i_rtc_event = 0, i_hf_sel = 0, i_lf_out_en = 1, i_radio_req = 0, i_retain_en = 1;
	reg  [1:0] i_mode_req = 2'h0, i_lf_sel = 2'h0;
	reg  [7:0] i_pin_level = 8'h00, i_wake_en = 8'h0f, i_gpio_out = 8'h00, i_gpio_oe_n = 8'hff, osc = 8'h00;
	reg  [7:0] pad_exp, oe_exp;
	wire [5:0] o_mode;
	wire [1:0] o_slow_src, o_reset_cause;
	wire [7:0] o_pad_out, o_pad_oe_n;
	wire       o_cpu_clk_en, o_aon_pwr_en, o_sram_retain, o_cpu_resume, o_sys_reset, o_fast_run;
	wire       o_fast_src, o_radio_en, o_slow_run, o_rtimer_sync, o_mem_clk_en, o_periph_clk_en, o_main_pwr_en;
	wire       o_sram_pwr_en, o_reg_retain, o_periph_retain, o_fast_rc_en, o_fast_xtal_en, o_slow_clk, o_rtc_en;
	wire       o_slow_out;
	integer    failures = 0, checks_done = 0, seed = 32'h6ab1, m, k, n, mdl = `PMCM_ST_ACTIVE;
	pmcm_manager #(.NPIN(8)) i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_reset_pin(i_reset_pin),
		.i_mode_req(i_mode_req), .i_mode_req_vld(i_mode_req_vld), .i_irq(i_irq), .i_ext_wake(i_ext_wake),
		.i_rtc_event(i_rtc_event), .i_hf_sel(i_hf_sel), .i_lf_sel(i_lf_sel), .i_lf_out_en(i_lf_out_en),
		.i_radio_req(i_radio_req), .i_retain_en(i_retain_en), .i_slow_rc(osc[1]), .i_slow_xtal(osc[2]),
		.i_slow_ext(osc[3]), .i_pin_level(i_pin_level), .i_wake_en(i_wake_en), .i_gpio_out(i_gpio_out),
		.i_gpio_oe_n(i_gpio_oe_n), .o_mode(o_mode), .o_cpu_clk_en(o_cpu_clk_en), .o_mem_clk_en(o_mem_clk_en),
		.o_periph_clk_en(o_periph_clk_en), .o_main_pwr_en(o_main_pwr_en), .o_aon_pwr_en(o_aon_pwr_en),
		.o_sram_retain(o_sram_retain), .o_sram_pwr_en(o_sram_pwr_en), .o_reg_retain(o_reg_retain),
		.o_periph_retain(o_periph_retain), .o_cpu_resume(o_cpu_resume), .o_sys_reset(o_sys_reset),
		.o_fast_run(o_fast_run), .o_fast_src(o_fast_src), .o_fast_rc_en(o_fast_rc_en),
		.o_fast_xtal_en(o_fast_xtal_en), .o_radio_en(o_radio_en), .o_slow_run(o_slow_run), .o_slow_src(o_slow_src),
		.o_slow_clk(o_slow_clk), .o_rtc_en(o_rtc_en), .o_rtimer_sync(o_rtimer_sync), .o_slow_out(o_slow_out),
		.o_reset_cause(o_reset_cause),
		.o_pad_out(o_pad_out), .o_pad_oe_n(o_pad_oe_n));
	// Clock and slow oscillator stand-ins
	initial
	begin
		forever #12.5 i_ref_clk = ~i_ref_clk;
	end
	always @(negedge i_ref_clk) osc <= osc + 8'h01;
	// Compare and report
	task chk(input string nm, input [7:0] seen, input [7:0] exp);
	begin
		checks_done = checks_done + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("wrong value %0s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	task step(input integer c);
	begin
		repeat (c) @(negedge i_ref_clk);
	end
	endtask
	// One-cycle mode request after an idle edge, then the mode the model predicts
	task req(input [1:0] code);
	begin
		step(1);
		i_mode_req = code;
		i_mode_req_vld = 1;
		step(1);
		i_mode_req_vld = 0;
		if (mdl == `PMCM_ST_ACTIVE && code != 2'h0)
			mdl = 1 << code;
		chk("mode", o_mode, mdl[7:0]);
	end
	endtask
	task wait_active;
	begin
		n = 0;
		while (o_mode !== `PMCM_ST_ACTIVE && n < 30)
		begin
			step(1);
			n = n + 1;
		end
		mdl = `PMCM_ST_ACTIVE;
		chk("mode", o_mode, `PMCM_ST_ACTIVE);
	end
	endtask
	task finish_test;
	begin
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		#(25 * 20000);
		failures = failures + 1;
		finish_test;
	end
	// Main sequence
	initial
	begin
		step(3);
		i_rst = 0;
		chk("mode", o_mode, `PMCM_ST_ACTIVE);
		chk("cause", o_reset_cause, `PMCM_CAUSE_POR);
		chk("cpu clk", o_cpu_clk_en, 1);
		req(2'h0);
		req(2'h1);
		chk("cpu clk", o_cpu_clk_en, 0);
		chk("mem clk", o_mem_clk_en, 0);
		chk("periph clk", o_periph_clk_en, 1);
		req(2'h2);
		chk("mode", o_mode, `PMCM_ST_IDLE);
		i_irq = 1;
		step(1);
		i_irq = 0;
		chk("mode", o_mode, `PMCM_ST_ACTIVE);
		mdl = `PMCM_ST_ACTIVE;
		$display("test idle done");
		for (k = 0; k < 2; k = k + 1)
		begin
			pad_exp = i_gpio_out;
			req(2'h2);
			chk("sync", o_rtimer_sync, 1);
			chk("sram ret", o_sram_retain, 1);
			chk("fast run", o_fast_run, 0);
			chk("periph ret", o_periph_retain, 1);
			chk("main pwr", o_main_pwr_en, 0);
			chk("sram pwr", o_sram_pwr_en, 1);
			chk("reg ret", o_reg_retain, 1);
			i_gpio_out = $random(seed);
			step(4);
			chk("mode", o_mode, `PMCM_ST_STANDBY);
			chk("pad", o_pad_out, pad_exp);
			if (k == 0) i_ext_wake = 1;
			else i_rtc_event = 1;
			step(1);
			i_ext_wake = 0;
			i_rtc_event = 0;
			chk("mode", o_mode, `PMCM_ST_WAKE);
			step(4);
			chk("mode", o_mode, `PMCM_ST_ACTIVE);
			chk("resume", o_cpu_resume, 1);
			mdl = `PMCM_ST_ACTIVE;
		end
		$display("test standby done");
		i_gpio_out = $random(seed);
		i_gpio_oe_n = $random(seed);
		step(3);
		pad_exp = i_gpio_out;
		oe_exp = i_gpio_oe_n;
		chk("pad", o_pad_out, pad_exp);
		chk("pad oe", o_pad_oe_n, oe_exp);
		req(2'h3);
		chk("aon", o_aon_pwr_en, 0);
		chk("main pwr", o_main_pwr_en, 0);
		chk("sram pwr", o_sram_pwr_en, 0);
		chk("reg ret", o_reg_retain, 0);
		chk("rtc", o_rtc_en, 0);
		i_gpio_out = ~i_gpio_out;
		i_gpio_oe_n = ~i_gpio_oe_n;
		i_pin_level = 8'h80;
		step(4);
		chk("mode", o_mode, `PMCM_ST_SHUTDOWN);
		chk("pad", o_pad_out, pad_exp);
		chk("pad oe", o_pad_oe_n, oe_exp);
		i_pin_level = 8'h82;
		wait_active;
		chk("cause", o_reset_cause, `PMCM_CAUSE_WAKE);
		$display("test shutdown done");
		for (m = 0; m < 4; m = m + 1)
		begin
			if (m > 0) req(m[1:0]);
			i_reset_pin = 1;
			step(1);
			chk("mode", o_mode, `PMCM_ST_HELD);
			chk("sys rst", o_sys_reset, 1);
			chk("fast run", o_fast_run, 0);
			step(2);
			i_reset_pin = 0;
			wait_active;
			chk("cause", o_reset_cause, `PMCM_CAUSE_PIN);
		end
		$display("test reset pin done");
		for (k = 0; k < 8; k = k + 1)
		begin
			i_hf_sel = $random(seed);
			i_lf_sel = {$random(seed)} % 3;
			i_radio_req = $random(seed);
			step(2);
			chk("fast src", o_fast_src, i_hf_sel);
			chk("radio", o_radio_en, i_radio_req & i_hf_sel);
			chk("slow src", o_slow_src, i_lf_sel);
			chk("slow run", o_slow_run, 1);
			chk("rtc", o_rtc_en, 1);
			chk("xtal en", o_fast_xtal_en, i_hf_sel);
			chk("rc en", o_fast_rc_en, !i_hf_sel);
			chk("slow clk", o_slow_clk, i_lf_sel == 2'h0 ? osc[1] : i_lf_sel == 2'h1 ? osc[2] : osc[3]);
			chk("slow out", o_slow_out, i_lf_sel == 2'h2 ? 1'b0 : i_lf_sel == 2'h0 ? osc[1] : osc[2]);
		end
		$display("test clocks done");
		i_rst = 1;
		step(3);
		i_rst = 0;
		step(1);
		chk("cause", o_reset_cause, `PMCM_CAUSE_POR);
		chk("pad oe", o_pad_oe_n, 8'hff);
		mdl = `PMCM_ST_ACTIVE;
		chk("mode", o_mode, mdl[7:0]);
		$display("test power on done");
		finish_test;
	end
endmodule

// file: logic/pmcm_edge_det.v
// Per-pin level change detector for shutdown wake pins.
// Assumes pin inputs synchronous to i_ref_clk.
`timescale 1ns/1ps
module pmcm_edge_det #(
	parameter N = 8
) (
	input  wire         i_ref_clk,  // Reference clock
	input  wire         i_rst,      // Async reset, high
	input  wire         i_arm,      // Capture reference levels
	input  wire [N-1:0] i_pins,     // Pin levels
	input  wire [N-1:0] i_en,       // Wake enable per pin
	output reg          o_change    // Change seen on an enabled pin
);
	reg [N-1:0] ref_lvl;
	wire [N-1:0] diff;
	genvar g;
	// Compare each pin against its reference
	generate
		for (g = 0; g < N; g = g + 1)
		begin : g_pin
			assign diff[g] = i_en[g] & (i_pins[g] ^ ref_lvl[g]);
		end
	endgenerate
	// Reference capture and change flag
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ref_lvl  <= {N{1'b0}};
			o_change <= 1'b0;
		end
		else if (i_arm)
		begin
			ref_lvl  <= i_pins;
			o_change <= 1'b0;
		end
		else
		begin
			o_change <= |diff;
		end
	end
endmodule

// file: logic/pmcm_io_latch.v
// Holding latch for general-purpose pin output state.
// Assumes the manager asserts i_hold across standby and shutdown.
`timescale 1ns/1ps
module pmcm_io_latch #(
	parameter N = 8
) (
	input  wire         i_ref_clk,  // Reference clock
	input  wire         i_rst,      // Async reset, high
	input  wire         i_hold,     // Freeze pins
	input  wire [N-1:0] i_out,      // Live pin value
	input  wire [N-1:0] i_oe_n,     // Live output enable, low drives
	output reg  [N-1:0] o_out,      // Pad value
	output reg  [N-1:0] o_oe_n      // Pad enable, low drives
);
	// Pass live values through unless held
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_out  <= {N{1'b0}};
			o_oe_n <= {N{1'b1}};
		end
		else if (!i_hold)
		begin
			o_out  <= i_out;
			o_oe_n <= i_oe_n;
		end
	end
endmodule

// file: logic/pmcm_manager.v
// Power-mode and clock manager: mode sequencing, domain enables, clock selects.
// Assumes software request strobes are one-cycle pulses synchronous to i_ref_clk.
// Functional notes
// - Active runs core and enabled peripherals
// - Idle gates core; interrupt returns active
// - Standby keeps always-on; wake by pin/timer
// - Standby wake resumes; retained peripherals kept; code: first WAKE cycle resets, drops retention if from_standby was 0
// - All general pins latched in standby
// - Shutdown powers all off; pins hold
// - Shutdown pin change wakes as reset
// - Reset cause recorded and readable
// - Shutdown keeps only pins and flash
// - Retention per mode; memory kept standby
// - Fast clock runs active/idle only
// - Reset pin wakes from every mode
// - Fast clock selects RC or crystal
// - Radio only when crystal sources clock
// - Slow clock: RC, crystal or pin
// - Slow clock drives timer and resync
// - Slow clock out only RC/crystal
`timescale 1ns/1ps
`include "pmcm_map.vh"
module pmcm_manager #(
	parameter NPIN = 8
) (
	input  wire            i_ref_clk,        // Reference clock 40 MHz
	input  wire            i_rst,            // Power-on reset, async high
	input  wire            i_reset_pin,      // External reset pin, high asserted
	input  wire [1:0]      i_mode_req,       // Software mode request code
	input  wire            i_mode_req_vld,   // Request strobe
	input  wire            i_irq,            // Any interrupt event
	input  wire            i_ext_wake,       // External wake event
	input  wire            i_rtc_event,      // Real-time clock event
	input  wire            i_hf_sel,         // Fast clock source select
	input  wire [1:0]      i_lf_sel,         // Slow clock source select
	input  wire            i_lf_out_en,      // Drive slow clock on pin
	input  wire            i_radio_req,      // Software wants radio on
	input  wire            i_retain_en,      // Peripheral retention enable
	input  wire            i_slow_rc,        // Slow RC oscillator level
	input  wire            i_slow_xtal,      // Slow crystal level
	input  wire            i_slow_ext,       // External slow clock on pin
	input  wire [NPIN-1:0] i_pin_level,      // Pin input levels
	input  wire [NPIN-1:0] i_wake_en,        // Shutdown wake pin enables
	input  wire [NPIN-1:0] i_gpio_out,       // Live pin output value
	input  wire [NPIN-1:0] i_gpio_oe_n,      // Live pin enable, low drives
	output reg  [5:0]      o_mode,           // One-hot mode state
	output reg             o_cpu_clk_en,     // Core clock enable
	output reg             o_mem_clk_en,     // Core memory clock enable
	output reg             o_periph_clk_en,  // Peripheral clock enable
	output reg             o_main_pwr_en,    // Main domain power
	output reg             o_aon_pwr_en,     // Always-on domain power
	output reg             o_sram_retain,    // SRAM retention mode
	output reg             o_sram_pwr_en,    // SRAM power
	output reg             o_reg_retain,     // Register retention on
	output reg             o_periph_retain,  // Peripheral config retention
	output reg             o_cpu_resume,     // Pulse: resume from standby
	output reg             o_sys_reset,      // Internal reset to main domain
	output reg             o_fast_run,       // Main fast clock running
	output reg             o_fast_src,       // Main fast clock source
	output reg             o_fast_rc_en,     // Fast RC oscillator enable
	output reg             o_fast_xtal_en,   // Fast crystal oscillator enable
	output reg             o_radio_en,       // Radio permitted and on
	output reg             o_slow_run,       // Slow clock running
	output reg  [1:0]      o_slow_src,       // Slow clock source
	output reg             o_slow_clk,       // Slow system clock level
	output reg             o_rtc_en,         // Real-time clock enable
	output reg             o_rtimer_sync,    // Pulse: resync radio timer
	output reg             o_slow_out,       // Slow clock to pin
	output reg  [1:0]      o_reset_cause,    // Reset cause status
	output reg  [NPIN-1:0] o_pad_out,        // Pad output values
	output reg  [NPIN-1:0] o_pad_oe_n        // Pad enables, low drives
);
	localparam [5:0] ST_ACTIVE   = `PMCM_ST_ACTIVE;
	localparam [5:0] ST_IDLE     = `PMCM_ST_IDLE;
	localparam [5:0] ST_STANDBY  = `PMCM_ST_STANDBY;
	localparam [5:0] ST_SHUTDOWN = `PMCM_ST_SHUTDOWN;
	localparam [5:0] ST_HELD     = `PMCM_ST_HELD;
	localparam [5:0] ST_WAKE     = `PMCM_ST_WAKE;
	localparam integer WAKE_CYC_I = `PMCM_WAKE_CYCLES;
	localparam [3:0] WAKE_CYC    = WAKE_CYC_I[3:0];

	reg  [5:0]      state;
	reg  [5:0]      next_state;
	reg  [3:0]      wake_cnt;
	reg             from_standby;
	reg             hold_pins;
	reg             arm_wake;
	reg             pin_seen;
	wire            pin_change;
	wire [NPIN-1:0] lat_out;
	wire [NPIN-1:0] lat_oe_n;

	// Mode powers: one decode used for several outputs
	function is_run;
		input [5:0] s;
		begin
			is_run = (s == ST_ACTIVE) | (s == ST_IDLE);
		end
	endfunction

	// Shutdown wake pin change detector
	pmcm_edge_det #(.N(NPIN)) u_edge (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_arm     (arm_wake),
		.i_pins    (i_pin_level),
		.i_en      (i_wake_en),
		.o_change  (pin_change)
	);

	// Pin holding latch
	pmcm_io_latch #(.N(NPIN)) u_latch (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_hold    (hold_pins),
		.i_out     (i_gpio_out),
		.i_oe_n    (i_gpio_oe_n),
		.o_out     (lat_out),
		.o_oe_n    (lat_oe_n)
	);

	// Next mode
	always @*
	begin
		next_state = state;
		arm_wake   = 1'b0;
		case (state)
			ST_ACTIVE:
			begin
				if (i_reset_pin)
					next_state = ST_HELD;
				else if (i_mode_req_vld)
				begin
					case (i_mode_req)
						`PMCM_REQ_IDLE:     next_state = ST_IDLE;
						`PMCM_REQ_STANDBY:  next_state = ST_STANDBY;
						`PMCM_REQ_SHUTDOWN:
						begin
							next_state = ST_SHUTDOWN;
							arm_wake   = 1'b1;
						end
						default:            next_state = ST_ACTIVE;
					endcase
				end
			end
			ST_IDLE:
			begin
				if (i_reset_pin)
					next_state = ST_HELD;
				else if (i_irq)
					next_state = ST_ACTIVE;
			end
			ST_STANDBY:
			begin
				if (i_reset_pin)
					next_state = ST_HELD;
				else if (i_ext_wake | i_rtc_event)
					next_state = ST_WAKE;
			end
			ST_SHUTDOWN:
			begin
				if (i_reset_pin | pin_change)
					next_state = ST_HELD;
			end
			ST_HELD:
			begin
				if (!i_reset_pin)
					next_state = ST_WAKE;
			end
			ST_WAKE:
			begin
				if (i_reset_pin)
					next_state = ST_HELD;
				else if (wake_cnt == WAKE_CYC - 4'h1)
					next_state = ST_ACTIVE;
			end
			default: next_state = ST_ACTIVE;
		endcase
	end

	// Mode register, wake timer, resume origin, reset cause
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state         <= ST_ACTIVE;
			wake_cnt      <= 4'h0;
			from_standby  <= 1'b0;
			pin_seen      <= 1'b0;
			o_reset_cause <= `PMCM_CAUSE_POR;
		end
		else
		begin
			state <= next_state;
			// Settle counter runs only while waking
			if (state == ST_WAKE)
				wake_cnt <= wake_cnt + 4'h1;
			else
				wake_cnt <= 4'h0;
			if (state == ST_STANDBY && next_state == ST_WAKE)
				from_standby <= 1'b1;
			else if (next_state == ST_HELD)
				from_standby <= 1'b0;
			// Cause fixed on entry to held reset; stale pin wake never reused
			if (next_state == ST_HELD && state != ST_HELD)
				pin_seen <= (state == ST_SHUTDOWN) & pin_change & ~i_reset_pin;
			if (state == ST_HELD && next_state == ST_WAKE)
				o_reset_cause <= pin_seen ? `PMCM_CAUSE_WAKE : `PMCM_CAUSE_PIN;
		end
	end

	// Domain, clock and retention controls from the next mode
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_mode          <= ST_ACTIVE;
			o_cpu_clk_en    <= 1'b1;
			o_mem_clk_en    <= 1'b1;
			o_periph_clk_en <= 1'b1;
			o_main_pwr_en   <= 1'b1;
			o_aon_pwr_en    <= 1'b1;
			o_sram_retain   <= 1'b0;
			o_sram_pwr_en   <= 1'b1;
			o_reg_retain    <= 1'b1;
			o_periph_retain <= 1'b0;
			o_cpu_resume    <= 1'b0;
			o_sys_reset     <= 1'b0;
			o_fast_run      <= 1'b1;
			o_fast_src      <= `PMCM_HF_RC;
			o_fast_rc_en    <= 1'b1;
			o_fast_xtal_en  <= 1'b0;
			o_radio_en      <= 1'b0;
			o_slow_run      <= 1'b1;
			o_slow_src      <= `PMCM_LF_RC;
			o_rtc_en        <= 1'b1;
			o_rtimer_sync   <= 1'b0;
			hold_pins       <= 1'b0;
		end
		else
		begin
			o_mode          <= next_state;
			o_cpu_clk_en    <= (next_state == ST_ACTIVE);
			o_mem_clk_en    <= (next_state == ST_ACTIVE);
			o_periph_clk_en <= is_run(next_state);
			o_main_pwr_en   <= is_run(next_state) | (next_state == ST_WAKE);
			o_aon_pwr_en    <= (next_state != ST_SHUTDOWN) & (next_state != ST_HELD);
			o_sram_retain   <= (next_state == ST_STANDBY);
			o_sram_pwr_en   <= is_run(next_state) | (next_state == ST_STANDBY) |
				(next_state == ST_WAKE & from_standby);
			o_reg_retain    <= is_run(next_state) | (next_state == ST_STANDBY) |
				(next_state == ST_WAKE & from_standby);
			o_periph_retain <= i_retain_en & ((next_state == ST_STANDBY) |
				(next_state == ST_WAKE & from_standby));
			o_cpu_resume    <= (state == ST_WAKE) & (next_state == ST_ACTIVE) & from_standby;
			o_sys_reset     <= (next_state == ST_HELD) | (next_state == ST_SHUTDOWN) |
				(next_state == ST_WAKE & ~from_standby);
			o_fast_run      <= is_run(next_state);
			o_fast_src      <= i_hf_sel;
			o_fast_rc_en    <= is_run(next_state) & (i_hf_sel == `PMCM_HF_RC);
			o_fast_xtal_en  <= is_run(next_state) & (i_hf_sel == `PMCM_HF_XTAL);
			o_radio_en      <= i_radio_req & is_run(next_state) & (i_hf_sel == `PMCM_HF_XTAL);
			o_slow_run      <= is_run(next_state) | (next_state == ST_STANDBY) | (next_state == ST_WAKE);
			o_slow_src      <= i_lf_sel;
			o_rtc_en        <= (next_state != ST_SHUTDOWN) & (next_state != ST_HELD);
			o_rtimer_sync   <= ((state == ST_ACTIVE) & (next_state == ST_STANDBY)) |
				((state == ST_WAKE) & (next_state == ST_ACTIVE) & from_standby);
			hold_pins       <= (next_state == ST_STANDBY) | (next_state == ST_SHUTDOWN) |
				((next_state == ST_HELD) & (state == ST_SHUTDOWN)) |
				(hold_pins & (next_state == ST_HELD));
		end
	end

	// Slow clock mux, slow clock output and pads
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_slow_clk <= 1'b0;
			o_slow_out <= 1'b0;
			o_pad_out  <= {NPIN{1'b0}};
			o_pad_oe_n <= {NPIN{1'b1}};
		end
		else
		begin
			case (o_slow_src)
				`PMCM_LF_RC:   o_slow_clk <= i_slow_rc & o_slow_run;
				`PMCM_LF_XTAL: o_slow_clk <= i_slow_xtal & o_slow_run;
				`PMCM_LF_EXT:  o_slow_clk <= i_slow_ext & o_slow_run;
				default:       o_slow_clk <= 1'b0;
			endcase
			o_slow_out <= i_lf_out_en & o_slow_run & (o_slow_src != `PMCM_LF_EXT) &
				(o_slow_src == `PMCM_LF_RC ? i_slow_rc : i_slow_xtal);
			o_pad_out  <= lat_out;
			o_pad_oe_n <= lat_oe_n;
		end
	end
endmodule

// file: logic/pmcm_map.vh
// Constants for the power-mode and clock manager.
// Assumes inclusion by bare name; definitions only.
`ifndef PMCM_MAP_VH
`define PMCM_MAP_VH
// Mode states, one-hot
`define PMCM_ST_ACTIVE   6'h01
`define PMCM_ST_IDLE     6'h02
`define PMCM_ST_STANDBY  6'h04
`define PMCM_ST_SHUTDOWN 6'h08
`define PMCM_ST_HELD     6'h10
`define PMCM_ST_WAKE     6'h20
// Software mode request codes
`define PMCM_REQ_NONE     2'h0
`define PMCM_REQ_IDLE     2'h1
`define PMCM_REQ_STANDBY  2'h2
`define PMCM_REQ_SHUTDOWN 2'h3
// Reset cause codes
`define PMCM_CAUSE_POR   2'h0
`define PMCM_CAUSE_PIN   2'h1
`define PMCM_CAUSE_WAKE  2'h2
// Slow clock source select
`define PMCM_LF_RC   2'h0
`define PMCM_LF_XTAL 2'h1
`define PMCM_LF_EXT  2'h2
// Fast clock source select
`define PMCM_HF_RC   1'b0
`define PMCM_HF_XTAL 1'b1
// Wake-to-active settle time, in ns, and cycles at 40 MHz
`define PMCM_CLK_PERIOD_NS 25
`define PMCM_WAKE_SETTLE_NS 100
`define PMCM_WAKE_CYCLES ((`PMCM_WAKE_SETTLE_NS + `PMCM_CLK_PERIOD_NS - 1) / `PMCM_CLK_PERIOD_NS)
`endif
